// file: acc_regs.svh
// Contract
// - Run bit one clears values then runs foreground; zero clears and skips.
// - Background linearity calibration runs only while bit one is set.
// - Foreground offset calibration runs only with the foreground run bit.
// - Background offset calibration needs background enable set as well.
// - Reference select zero calibrates offset toward mid-scale code.
// - Reference select one matches primary offset to the spare converter.
// - Offset averaging field bits six to four, reset six.
// - Linearity averaging field bits two to zero, reset one.
// - Status register is read-only; status code in bits four to two.
// - Background-stopped flag rises when background halts at requested phase.
// - Background-stopped flag clears as soon as calibration resumes.
// - With background disabled, stopped flag sets when foreground ends or skips.
// - Foreground-complete flag rises when foreground finishes or is skipped.
// - Calibration runs while master enable is high; low holds it in reset.
// - Pin select routes complete, stopped, alarm or low to status pin.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_IDX_MODE 8'h62
`define ACC_IDX_OFFSET_REFERENCE_SELECT 8'h65
`define ACC_IDX_AVG 8'h68
`define ACC_IDX_STAT 8'h6a
`define ACC_IDX_CTRL 8'h70
`define ACC_IDX_IRQ_ST 8'h71
`define ACC_IDX_IRQ_EN 8'h72
`define ACC_IDX_IRQ_CLR 8'h73
`define ACC_RST_MODE 8'h01
`define ACC_RST_OFFSET_REFERENCE_SELECT 8'h01
`define ACC_RST_AVG 8'h61
`define ACC_RST_CTRL 8'h01
`define ACC_BIT_FG 0
`define ACC_BIT_BG 1
`define ACC_BIT_OS 2
`define ACC_BIT_BGOS 3
`define ACC_BIT_OFFSET_REFERENCE_SELECT 2
`define ACC_OSAVG_LSB 4
`define ACC_LINAVG_LSB 0
`define ACC_STAT_LSB 2
`define ACC_FG_BASE 16
`define ACC_BG_PHASE 32
`endif

// file: acc_pkg.sv
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b000,
    ACC_CLEAR = 3'b001,
    ACC_FG = 3'b010,
    ACC_BG = 3'b011,
    ACC_HALT = 3'b100
  } acc_state_e;
endpackage

// file: acc_cal_cfg.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module acc_cal_cfg
  import acc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bg_stop_request,
  input wire logic alarm_in,
  output logic calibration_status_pin,
  output logic irq,
  output logic [7:0] run_config,
  output logic [7:0] run_averaging
);
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction
  function automatic logic ok_idx(input logic [7:0] i, input logic wr);
    ok_idx = (i == `ACC_IDX_MODE) || (i == `ACC_IDX_OFFSET_REFERENCE_SELECT) ||
             (i == `ACC_IDX_AVG) || (i == `ACC_IDX_CTRL) ||
             (i == `ACC_IDX_IRQ_EN) || (i == `ACC_IDX_IRQ_CLR && wr) ||
             ((i == `ACC_IDX_STAT || i == `ACC_IDX_IRQ_ST) && !wr);
  endfunction

  logic [7:0] mode_reg, offset_reference_select_reg, avg_reg, ctrl_reg, irq_en_reg;
  logic [1:0] irq_st_reg;
  logic [31:0] aw_reg, w_reg;
  logic aw_ok_reg, w_ok_reg, awready_reg, wready_reg, bvalid_reg;
  logic wst_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [7:0] runcfg_reg, runavg_reg;
  acc_state_e state_reg, state_next;
  logic [5:0] cnt_reg;
  logic foreground_complete_flag_reg, stopped_reg, pin_reg, irq_reg;
  logic [2:0] code_reg;

  wire aw_hs = s_axi_awvalid && awready_reg;
  wire w_hs = s_axi_wvalid && wready_reg;
  wire do_wr = aw_ok_reg && w_ok_reg && !bvalid_reg;
  wire [7:0] wr_idx = idx_of(aw_reg);
  wire wr_good = ok_idx(wr_idx, 1'b1);
  wire wr_lane = wst_reg && do_wr && wr_good;
  wire [7:0] wd = w_reg[7:0];
  wire ar_hs = s_axi_arvalid && arready_reg;
  wire [7:0] rd_idx = idx_of(s_axi_araddr);
  wire [7:0] stat_byte = {3'b000, code_reg, stopped_reg, foreground_complete_flag_reg};
  wire [7:0] rd_byte =
    (rd_idx == `ACC_IDX_MODE) ? mode_reg :
    (rd_idx == `ACC_IDX_OFFSET_REFERENCE_SELECT) ? offset_reference_select_reg :
    (rd_idx == `ACC_IDX_AVG) ? avg_reg :
    (rd_idx == `ACC_IDX_STAT) ? stat_byte :
    (rd_idx == `ACC_IDX_CTRL) ? ctrl_reg :
    (rd_idx == `ACC_IDX_IRQ_ST) ? {6'd0, irq_st_reg} :
    (rd_idx == `ACC_IDX_IRQ_EN) ? irq_en_reg : 8'h00;
  wire cal_en = ctrl_reg[0];
  wire fg_run = runcfg_reg[`ACC_BIT_FG];
  wire bg_on = runcfg_reg[`ACC_BIT_BG];
  wire fg_ev = (state_reg == ACC_FG && cnt_reg == 6'd0) ||
               (state_reg == ACC_CLEAR && !fg_run);
  wire stop_ev = state_reg == ACC_BG && bg_stop_request &&
                 cnt_reg == 6'd0;
  wire [1:0] pin_sel = ctrl_reg[2:1];
  wire pin_next = (pin_sel == 2'd0) ? foreground_complete_flag_reg :
                  (pin_sel == 2'd1) ? stopped_reg :
                  (pin_sel == 2'd2) ? alarm_in : 1'b0;
  wire [1:0] ev = {stop_ev || (fg_ev && !bg_on), fg_ev};
  // Linearity depth from the run's snapshot; offset passes lengthen the foreground and shorten
  // the background phase, only when their enable pairs with the run mode that carries them.
  wire os_fg = runcfg_reg[`ACC_BIT_OS] && fg_run;
  wire os_bg = runcfg_reg[`ACC_BIT_BGOS] && bg_on;
  wire [5:0] fg_len = 6'(`ACC_FG_BASE) +
    6'(runavg_reg[2:0]) + (os_fg ? 6'(runavg_reg[6:4]) : 6'd0);
  wire [5:0] bg_len = 6'(`ACC_BG_PHASE) - 6'd1 -
    (os_bg ? 6'(runavg_reg[6:4]) : 6'd0);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ACC_IDLE: if (cal_en) state_next = ACC_CLEAR;
      ACC_CLEAR: state_next = fg_run ? ACC_FG : (bg_on ? ACC_BG : ACC_IDLE);
      ACC_FG: if (cnt_reg == 6'd0) state_next = bg_on ? ACC_BG : ACC_HALT;
      ACC_BG: if (stop_ev) state_next = ACC_HALT;
      ACC_HALT: if (bg_on && !bg_stop_request) state_next = ACC_BG;
      default: state_next = ACC_IDLE;
    endcase
    if (!cal_en) state_next = ACC_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ACC_IDLE;
      cnt_reg <= 6'd0;
      runcfg_reg <= `ACC_RST_MODE;
      runavg_reg <= `ACC_RST_AVG;
      foreground_complete_flag_reg <= 1'b0;
      stopped_reg <= 1'b0;
      code_reg <= 3'd0;
    end
    else
    begin
      state_reg <= state_next;
      code_reg <= state_next;
      if (state_reg == ACC_IDLE && cal_en)
      begin
        // The reference select rides in bit four, a reserved mode bit, so
        // the offset enables keep their own positions in the snapshot.
        runcfg_reg <= {mode_reg[7:5], offset_reference_select_reg[`ACC_BIT_OFFSET_REFERENCE_SELECT],
                       mode_reg[3:0]};
        runavg_reg <= avg_reg;
      end
      if (state_reg == ACC_CLEAR)
        cnt_reg <= fg_len;
      else if (state_reg == ACC_FG && cnt_reg == 6'd0)
        cnt_reg <= bg_len;
      else if (state_reg == ACC_BG && cnt_reg == 6'd0)
        cnt_reg <= bg_len;
      else if (cnt_reg != 6'd0)
        cnt_reg <= cnt_reg - 6'd1;
      if (!cal_en || state_reg == ACC_IDLE)
        foreground_complete_flag_reg <= 1'b0;
      else if (fg_ev)
        foreground_complete_flag_reg <= 1'b1;
      if (!cal_en || (state_reg == ACC_HALT && state_next == ACC_BG))
        stopped_reg <= 1'b0;
      else if (stop_ev)
        stopped_reg <= 1'b1;
      else if (fg_ev && !bg_on)
        stopped_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= `ACC_RST_MODE;
      offset_reference_select_reg <= `ACC_RST_OFFSET_REFERENCE_SELECT;
      avg_reg <= `ACC_RST_AVG;
      ctrl_reg <= `ACC_RST_CTRL;
      irq_en_reg <= 8'h00;
      irq_st_reg <= 2'b00;
      pin_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      pin_reg <= pin_next;
      irq_reg <= |(irq_st_reg & irq_en_reg[1:0]);
      if (wr_lane && wr_idx == `ACC_IDX_MODE) mode_reg <= wd;
      if (wr_lane && wr_idx == `ACC_IDX_OFFSET_REFERENCE_SELECT) offset_reference_select_reg <= wd;
      if (wr_lane && wr_idx == `ACC_IDX_AVG) avg_reg <= wd;
      if (wr_lane && wr_idx == `ACC_IDX_CTRL) ctrl_reg <= wd;
      if (wr_lane && wr_idx == `ACC_IDX_IRQ_EN) irq_en_reg <= wd;
      // An event in the clear cycle wins so that no completion is lost.
      irq_st_reg <= (irq_st_reg &
        ~((wr_lane && wr_idx == `ACC_IDX_IRQ_CLR) ? wd[1:0] : 2'b00)) | ev;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      aw_reg <= 32'h0000_0000;
      w_reg <= 32'h0000_0000;
      wst_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_reg <= s_axi_awaddr;
        aw_ok_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs)
      begin
        // The lane strobe is kept apart so data bit zero cannot mask it.
        w_reg <= {24'h00_0000, s_axi_wdata[7:0]};
        wst_reg <= s_axi_wstrb[0];
        w_ok_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_wr)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_good ? 2'b00 : 2'b10;
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
      if (ar_hs)
      begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= ok_idx(rd_idx, 1'b0) ? 2'b00 : 2'b10;
      end
      if (rvalid_reg && s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign calibration_status_pin = pin_reg;
  assign irq = irq_reg;
  assign run_config = runcfg_reg;
  assign run_averaging = runavg_reg;

  a_skip_sets_done: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_CLEAR && !fg_run && cal_en |=> foreground_complete_flag_reg)
    else $error("skip did not set complete flag");
  a_bg_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_BG |-> bg_on)
    else $error("background ran while disabled");
  a_foreground_complete_flag_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_FG && cnt_reg == 6'd0 && cal_en |=> foreground_complete_flag_reg)
    else $error("complete flag missed");
  a_stop_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_ev && cal_en |=> stopped_reg && state_reg == ACC_HALT)
    else $error("stopped flag missed");
  a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_BG && $past(state_reg) == ACC_HALT |-> !stopped_reg)
    else $error("stopped flag held on resume");
  a_fg_only_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    fg_ev && !bg_on && cal_en |=> stopped_reg)
    else $error("stopped flag missed without background");
  a_master_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !cal_en |=> state_reg == ACC_IDLE ##1 !foreground_complete_flag_reg)
    else $error("calibration ran while held");
  a_pin_route: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_sel == 2'd3 |=> !calibration_status_pin)
    else $error("status pin not low");
  a_snapshot: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg != ACC_IDLE && state_next != ACC_IDLE |=> $stable(runavg_reg))
    else $error("settings changed mid run");
  // Bus side checks; a response stands until the master takes it.
  a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_axi_rvalid)
    else $error("read response missing");
  a_bvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_aw_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_ok_reg |-> !s_axi_awready)
    else $error("address taken while one is pending");
  a_w_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    w_ok_reg |-> !s_axi_wready)
    else $error("data taken while one is pending");
  a_wr_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_rd_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_bad_wr_err: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && !wr_good |=> s_axi_bresp == 2'b10)
    else $error("bad write not refused");
  a_good_wr_ok: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && wr_good |=> s_axi_bresp == 2'b00)
    else $error("good write refused");
  a_status_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && wr_idx == `ACC_IDX_STAT |=> s_axi_bresp == 2'b10)
    else $error("status write accepted");
  a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_clear_first: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_IDLE && cal_en |=> state_reg == ACC_CLEAR)
    else $error("run did not clear first");
  a_fg_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_CLEAR && !fg_run |=> state_reg != ACC_FG)
    else $error("foreground ran while skipped");
  a_fg_start: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_CLEAR && fg_run && cal_en |=> state_reg == ACC_FG)
    else $error("foreground did not start");
  a_lin_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_CLEAR && !os_fg |=>
    cnt_reg == 6'(`ACC_FG_BASE) + 6'($past(runavg_reg[2:0])))
    else $error("linearity depth wrong");
  a_os_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_CLEAR && os_fg |=> cnt_reg == 6'(`ACC_FG_BASE) +
    6'($past(runavg_reg[2:0])) + 6'($past(runavg_reg[6:4])))
    else $error("offset depth wrong");
  a_bg_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_FG && cnt_reg == 6'd0 && bg_on && cal_en |=>
    state_reg == ACC_BG)
    else $error("background did not follow");
  a_fg_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_FG && cnt_reg == 6'd0 && !bg_on && cal_en |=>
    state_reg == ACC_HALT)
    else $error("no halt after foreground");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(irq_st_reg & irq_en_reg[1:0]) |=> irq)
    else $error("interrupt missed");
  a_pin_done: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_sel == 2'd0 |=> calibration_status_pin == $past(foreground_complete_flag_reg))
    else $error("pin not following complete flag");
  a_pin_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_sel == 2'd1 |=> calibration_status_pin == $past(stopped_reg))
    else $error("pin not following stopped flag");
  c_fg_run: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_FG ##[1:40] foreground_complete_flag_reg);
  c_bg_halt: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_BG ##[1:40] state_reg == ACC_HALT);
  c_resume: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ACC_HALT ##1 state_reg == ACC_BG);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule
`default_nettype wire

// file: adc_calibration_config_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"
module adc_calibration_config_status_test;
  logic aclk = 0;
  logic aresetn = 0;
  logic [31:0] awa = '0;
  logic [31:0] wd = '0;
  logic [31:0] ara = '0;
  logic awv = 0;
  logic wv = 0;
  logic arv = 0;
  logic stop = 0;
  logic alarm = 0;
  wire logic awr, wrd, bv, arr, rv, pin, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat;
  wire logic [7:0] rcfg, ravg;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed = 45169;
  logic [31:0] d;
  logic [1:0] r;
  logic [2:0] a3, b3;
  logic [7:0] v;

  always #12.5 aclk = ~aclk;

  // Ready lines are held high throughout; byte lane 0 carries every register.
  acc_cal_cfg dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .bg_stop_request(stop),
    .alarm_in(alarm), .calibration_status_pin(pin), .irq(irq),
    .run_config(rcfg), .run_averaging(ravg)
  );

  task automatic tally_and_finish;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Ready is judged at the falling edge so that it matches the value
  // the slave presents at the following rising edge.
  task automatic wr(input logic [7:0] i, input logic [7:0] x);
    logic ga, gw, ta, tw;
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awa <= {22'h0, i, 2'h0};
    wd <= {24'h0, x};
    awv <= 1;
    wv <= 1;
    while (!(ga && gw))
    begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrd;
      @(posedge aclk);
      awv <= awv && !ta;
      wv <= wv && !tw;
      ga = ga | ta;
      gw = gw | tw;
    end
    do @(negedge aclk); while (!bv);
    r = bresp;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] i);
    @(posedge aclk);
    ara <= {22'h0, i, 2'h0};
    arv <= 1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 0;
    do @(negedge aclk); while (!rv);
    d = rdat;
    r = rresp;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge aclk);
  endtask

  task automatic wst(input logic [7:0] m, input logic [7:0] e);
    for (int k = 0; k < 100; k++)
    begin
      rd(`ACC_IDX_STAT);
      if ((d[7:0] & m) == e)
        break;
    end
    chk(d[7:0] & m, e);
  endtask

  initial
  begin
    v = $random(seed);
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rd(`ACC_IDX_MODE);
    chk(d[7:0], 8'h01);
    rd(`ACC_IDX_OFFSET_REFERENCE_SELECT);
    chk(d[7:0], 8'h01);
    rd(`ACC_IDX_AVG);
    chk(d[7:0], 8'h61);
    wst(8'h03, 8'h03);
    chk(rcfg, 8'h01);
    chk(ravg, 8'h61);
    rd(8'h00);
    chk({6'h0, r}, 8'h02);
    wr(`ACC_IDX_STAT, 8'hff);
    chk({6'h0, r}, 8'h02);
    rd(`ACC_IDX_IRQ_CLR);
    chk({6'h0, r}, 8'h02);
    for (int s = 0; s < 4; s++)
    begin
      alarm <= 1'($random(seed));
      wr(`ACC_IDX_CTRL, 8'(s * 2 + 1));
      settle(3);
      chk(pin, (s == 2) ? alarm : (s < 2));
    end
    wr(`ACC_IDX_IRQ_EN, 8'h01);
    settle(3);
    chk(irq, 1);
    wr(`ACC_IDX_IRQ_EN, 8'h00);
    settle(3);
    chk(irq, 0);
    wr(`ACC_IDX_CTRL, 8'h00);
    wst(8'h03, 8'h00);
    wr(`ACC_IDX_IRQ_CLR, 8'h03);
    rd(`ACC_IDX_IRQ_ST);
    chk(d[7:0] & 8'h03, 8'h00);
    wr(`ACC_IDX_IRQ_EN, 8'h02);
    a3 = 3'($random(seed));
    b3 = 3'($random(seed));
    v = {1'b0, b3, 1'b0, a3};
    wr(`ACC_IDX_AVG, v);
    rd(`ACC_IDX_AVG);
    chk(d[7:0], v);
    wr(`ACC_IDX_MODE, 8'h05);
    wr(`ACC_IDX_CTRL, 8'h01);
    wst(8'h03, 8'h03);
    chk(rcfg, 8'h05);
    chk(ravg, v);
    // Spare reference is chosen together with background enable, foreground skipped.
    wr(`ACC_IDX_CTRL, 8'h00);
    wr(`ACC_IDX_MODE, 8'h0a);
    wr(`ACC_IDX_OFFSET_REFERENCE_SELECT, 8'h05);
    wr(`ACC_IDX_CTRL, 8'h03);
    wst(8'h01, 8'h01);
    settle(40);
    rd(`ACC_IDX_STAT);
    chk({6'h0, d[1:0]}, 8'h01);
    chk({5'h0, d[4:2]}, 8'h03);
    wr(`ACC_IDX_MODE, 8'h01);
    chk(rcfg, 8'h1a);
    @(posedge aclk);
    stop <= 1;
    wst(8'h02, 8'h02);
    chk({5'h0, d[4:2]}, 8'h04);
    settle(3);
    chk(pin, 1);
    chk(irq, 1);
    @(posedge aclk);
    stop <= 0;
    wst(8'h02, 8'h00);
    settle(3);
    chk(pin, 0);
    wr(`ACC_IDX_IRQ_CLR, 8'h02);
    settle(3);
    chk(irq, 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
